// ===== src/acpfc_firing_ctrl.sv
// ac phase firing controller: frequency detection, set-point sampling, triac firing
`timescale 1ns/10ps

// Overview of operation
// - triac gate comes straight from one output flip-flop, no isolating stage.
// - after reset a configure step precedes supply frequency detection.
// - comparator and delay timer events decide each half cycle's firing moment.
// - during detection the timer runs from one comparator event to the next.
// - captured period is compared to a threshold: 50 Hz or 60 Hz.
// - classification accepted only after five equal consecutive results.
// - no valid frequency found: permanent halt, speed control never enabled.
// - the potentiometer is sampled through the converter again and again.
// - firing delay reload is refreshed from the table by the latest reading.
// - minimum to maximum potentiometer raises speed from standstill to full.
// - each zero crossing restarts the delay timer with the current reload.
// - delay timer expiry issues a gate pulse on the triac output.
// - firing repeats every half period, timer reloaded every time.
module acpfc_firing_ctrl
   import acpfc_pkg::*;
#(
   parameter int TICK_DIV = acpfc_pkg::TICK_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   clk_en,
   input  wire logic                   mains_sense_in,
   input  wire acpfc_pkg::acpfc_adc_t  setpoint_adc_in,
   output logic                        triac_gate_out,
   output logic                        adc_start_out,
   output acpfc_pkg::acpfc_stat_t      status_out
);
   // --------------------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------------------
   acpfc_state_t     state_reg;
   logic [TICK_W-1:0] pre_reg;
   logic             tick_reg;
   logic             mains_q_reg;
   logic             zc;
   logic [CNT_W-1:0] meas_cnt;
   logic [CNT_W-1:0] delay_cnt;
   logic [CNT_W-1:0] rom_q;
   logic [CNT_W-1:0] target_next;
   logic [CNT_W-1:0] target_reg;
   logic             armed_reg;
   logic             fire;
   logic [GATE_W-1:0] gate_cnt_reg;
   logic             triac_gate_reg;
   logic             adc_start_reg;
   logic             adc_busy_reg;
   logic [ADC_W-1:0] adc_code_reg;
   logic [IDX_W-1:0] idx_reg;
   logic [14:0]      idx_prod;
   logic             meas_ok;
   logic             meas_is50;
   logic             last50_reg;
   logic [2:0]       streak_reg;
   logic [2:0]       streak_next;
   logic [4:0]       tries_reg;
   acpfc_stat_t      status_reg;

   // --------------------------------------------------------------------------
   // timer tick prescaler and zero-crossing events
   // --------------------------------------------------------------------------
   // one tick per TICK_DIV clocks; all period and delay figures count ticks
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pre_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         tick_reg <= (pre_reg == TICK_W'(TICK_DIV - 1));
         pre_reg  <= (pre_reg == TICK_W'(TICK_DIV - 1)) ? '0 : pre_reg + TICK_W'(1);
      end
   end

   // comparator output is synchronous; both edges mark a crossing each half cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         mains_q_reg <= 1'b0;
      else if (clk_en)
         mains_q_reg <= mains_sense_in;
   end

   // the first sample after reset is not an edge: the configure state gates it out
   assign zc = clk_en && (mains_sense_in ^ mains_q_reg) && (state_reg != ST_CONFIG);

   // --------------------------------------------------------------------------
   // period and delay timers
   // --------------------------------------------------------------------------
   // period timer starts on one event and is read on the next
   acpfc_tick_counter #(.W(CNT_W)) u_period (
      .clk       (clk),
      .rst_b     (rst_b),
      .ce        (clk_en),
      .clr       (zc),
      .inc       (tick_reg && (state_reg == ST_SYNC || state_reg == ST_MEASURE)),
      .count_reg (meas_cnt)
   );

   // delay timer restarts at every crossing while running
   acpfc_tick_counter #(.W(CNT_W)) u_delay (
      .clk       (clk),
      .rst_b     (rst_b),
      .ce        (clk_en),
      .clr       (zc),
      .inc       (tick_reg && armed_reg),
      .count_reg (delay_cnt)
   );

   // --------------------------------------------------------------------------
   // frequency classification
   // --------------------------------------------------------------------------
   assign meas_ok   = (meas_cnt >= MIN_TK) && (meas_cnt <= MAX_TK);
   assign meas_is50 = (meas_cnt > THRESH_TK);

   // a spike breaks the run; a differing valid result starts a new run
   always_comb
   begin
      if (!meas_ok)
         streak_next = 3'h0;
      else if (streak_reg != 3'h0 && meas_is50 == last50_reg)
         streak_next = streak_reg + 3'h1;
      else
         streak_next = 3'h1;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         streak_reg <= 3'h0;
         last50_reg <= 1'b0;
         tries_reg  <= 5'h00;
      end
      else if (zc && state_reg == ST_MEASURE)
      begin
         streak_reg <= streak_next;
         last50_reg <= meas_is50;
         tries_reg  <= tries_reg + 5'h01;
      end
   end

   // --------------------------------------------------------------------------
   // control state machine
   // --------------------------------------------------------------------------
   // halt is a dead end: only reset leaves it
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         state_reg <= ST_CONFIG;
      else if (clk_en)
      begin
         case (state_reg)
            ST_CONFIG:  state_reg <= ST_SYNC;
            ST_SYNC:
               if (zc)
                  state_reg <= ST_MEASURE;
               else if (meas_cnt >= MAX_TK)
                  state_reg <= ST_HALT;
            ST_MEASURE:
               if (zc && streak_next == DET_RUN)
                  state_reg <= ST_RUN;
               else if (zc && tries_reg == DET_TRIES - 5'h01)
                  state_reg <= ST_HALT;
               else if (!zc && meas_cnt >= MAX_TK)
                  state_reg <= ST_HALT;
            ST_RUN:     state_reg <= ST_RUN;
            default:    state_reg <= ST_HALT;
         endcase
      end
   end

   // status carries the accepted classification
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         status_reg <= '0;
      else if (clk_en && zc && state_reg == ST_MEASURE && streak_next == DET_RUN)
         status_reg <= '{halted: 1'b0, freq_ok: 1'b1, is_50hz: meas_is50};
      else if (clk_en)
         status_reg.halted <= (state_reg == ST_HALT);
   end

   // --------------------------------------------------------------------------
   // background set-point sampling
   // --------------------------------------------------------------------------
   // a new conversion is asked for as soon as the last one returned
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         adc_start_reg <= 1'b0;
         adc_busy_reg  <= 1'b0;
         adc_code_reg  <= '0;
      end
      else if (clk_en)
      begin
         adc_start_reg <= !adc_busy_reg && (state_reg != ST_CONFIG);
         if (setpoint_adc_in.valid && adc_busy_reg)
         begin
            adc_busy_reg <= 1'b0;
            adc_code_reg <= setpoint_adc_in.code;
         end
         else if (!adc_busy_reg && state_reg != ST_CONFIG)
            adc_busy_reg <= 1'b1;
      end
   end

   // scale the reading to a table index, 0 at minimum up to 19
   assign idx_prod = 15'(adc_code_reg) * IDX_MUL;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         idx_reg <= '0;
      else if (clk_en)
         idx_reg <= idx_prod[14:10];
   end

   acpfc_delay_rom u_rom (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (clk_en),
      .addr     (idx_reg),
      .data_reg (rom_q)
   );

   // table is in 60 Hz ticks; a 50 Hz supply stretches it by 6/5
   assign target_next = status_reg.is_50hz ? rom_q + CNT_W'(rom_q / DIV_50) : rom_q;

   // --------------------------------------------------------------------------
   // firing
   // --------------------------------------------------------------------------
   assign fire = armed_reg && (delay_cnt >= target_reg) && !zc;

   // full-delay entry is standstill: the timer is never armed for it
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         armed_reg  <= 1'b0;
         target_reg <= HALF_60_TK;
      end
      else if (clk_en)
      begin
         if (zc && state_reg == ST_RUN)
         begin
            armed_reg  <= (rom_q != DELAY_LUT[0]);
            target_reg <= target_next;
         end
         else if (fire)
            armed_reg <= 1'b0;
      end
   end

   // gate pulse ends after its width or at the next crossing, whichever first
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         triac_gate_reg <= 1'b0;
         gate_cnt_reg   <= '0;
      end
      else if (clk_en)
      begin
         if (state_reg != ST_RUN || zc)
            triac_gate_reg <= 1'b0;
         else if (fire)
         begin
            triac_gate_reg <= 1'b1;
            gate_cnt_reg   <= GATE_TK;
         end
         else if (tick_reg && gate_cnt_reg != '0)
            gate_cnt_reg <= gate_cnt_reg - GATE_W'(1);
         else if (gate_cnt_reg == '0)
            triac_gate_reg <= 1'b0;
      end
   end

   // outputs straight from flip-flops, no isolating stage in the path
   assign triac_gate_out = triac_gate_reg;
   assign adc_start_out  = adc_start_reg;
   assign status_out     = status_reg;

   // --------------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_run_crossing;
      state_reg == ST_RUN && zc;
   endsequence

   sequence s_last_equal;
      state_reg == ST_MEASURE && zc && streak_next == DET_RUN;
   endsequence

   AST_GATE_IDLE: assert property (status_reg.freq_ok == 1'b0 |-> !triac_gate_out)
      else $error("gate active before a frequency was classified");
   AST_HALT_STUCK: assert property (state_reg == ST_HALT |=> state_reg == ST_HALT
      && !status_reg.freq_ok) else $error("halt state was left");
   AST_CONFIG_FIRST: assert property ($rose(rst_b) |-> state_reg == ST_CONFIG)
      else $error("detection began without the configure step");
   AST_MEAS_START: assert property (state_reg == ST_SYNC && zc |=>
      state_reg == ST_MEASURE && meas_cnt == '0) else $error("period timer not started");
   AST_ACCEPT: assert property (s_last_equal |=> state_reg == ST_RUN
      && status_reg.freq_ok && status_reg.is_50hz == $past(meas_is50))
      else $error("run of equal results not accepted");
   AST_NO_EARLY: assert property ($rose(status_reg.freq_ok) |-> tries_reg >= 5'(DET_RUN))
      else $error("frequency accepted after fewer than five results");
   AST_RELOAD: assert property (s_run_crossing |=> delay_cnt == '0
      && target_reg == $past(target_next)) else $error("delay timer not reloaded");
   AST_FIRE: assert property (state_reg == ST_RUN && fire |=> triac_gate_out ##1
      !armed_reg) else $error("expiry did not fire the gate");
   AST_ADC_AGAIN: assert property ($fell(adc_busy_reg) && clk_en |-> ##[1:2]
      adc_start_reg) else $error("set-point sampling stopped");
   AST_ADC_PULSE: assert property (adc_start_reg && clk_en |=> !adc_start_reg)
      else $error("conversion request longer than one cycle");
endmodule : acpfc_firing_ctrl

// ===== shared/acpfc_pkg.sv
// package: constants, carrier types and states of the ac phase firing controller
package acpfc_pkg;
   // --------------------------------------------------------------------------
   // timing
   // --------------------------------------------------------------------------
   localparam int CLK_NS   = 10;                 // system clock period, 100 MHz
   localparam int TICK_NS  = 1447;               // delay timer tick, about 1.45 us
   localparam int TICK_CYC = TICK_NS / CLK_NS;   // clock cycles per timer tick
   localparam int GATE_US  = 100;                // triac gate pulse width
   localparam int GATE_TKI = (GATE_US * 1000) / TICK_NS;
   localparam int TICK_W   = 16;
   localparam int CNT_W    = 13;
   localparam int GATE_W   = 8;
   localparam logic [GATE_W-1:0] GATE_TK = GATE_TKI[GATE_W-1:0];

   // --------------------------------------------------------------------------
   // half period figures in timer ticks
   // --------------------------------------------------------------------------
   localparam logic [CNT_W-1:0] HALF_60_TK = 13'h1680;   // 8.33 ms
   localparam logic [CNT_W-1:0] HALF_50_TK = 13'h1B00;   // 10 ms
   localparam logic [CNT_W-1:0] THRESH_TK  = 13'h18C0;   // between the two
   localparam logic [CNT_W-1:0] MIN_TK     = 13'h12C0;   // shorter is a spike
   localparam logic [CNT_W-1:0] MAX_TK     = 13'h1F40;   // longer is no mains
   localparam logic [CNT_W-1:0] DIV_50     = 13'h0005;   // 50 Hz scale is 6/5
   localparam logic [2:0]       DET_RUN    = 3'h5;       // consecutive equal results
   localparam logic [4:0]       DET_TRIES  = 5'h10;      // measurements before halt

   // --------------------------------------------------------------------------
   // set-point lookup
   // --------------------------------------------------------------------------
   localparam int ADC_W = 10;
   localparam int IDX_W = 5;
   localparam int LUT_N = 20;
   localparam logic [14:0] IDX_MUL = 15'h0014;           // code * 20 / 1024
   localparam logic [CNT_W-1:0] DELAY_LUT [LUT_N] = '{
      13'h1680, 13'h1560, 13'h1440, 13'h1320, 13'h1200, 13'h10E0, 13'h0FC0,
      13'h0EA0, 13'h0D80, 13'h0C60, 13'h0B40, 13'h0A20, 13'h0900, 13'h07E0,
      13'h06C0, 13'h05A0, 13'h0480, 13'h0360, 13'h0240, 13'h0120};

   // --------------------------------------------------------------------------
   // carriers and states
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic             valid;   // one-cycle strobe with a finished conversion
      logic [ADC_W-1:0] code;    // potentiometer reading
   } acpfc_adc_t;

   typedef struct packed {
      logic halted;    // no valid supply frequency, control locked out
      logic freq_ok;   // supply classified, speed control running
      logic is_50hz;   // classification: 1 = 50 Hz, 0 = 60 Hz
   } acpfc_stat_t;

   typedef enum logic [2:0] {ST_CONFIG, ST_SYNC, ST_MEASURE, ST_RUN, ST_HALT} acpfc_state_t;
endpackage : acpfc_pkg

// ===== src/acpfc_tick_counter.sv
// counter of timer ticks with synchronous clear, used for period and delay
`timescale 1ns/10ps
module acpfc_tick_counter #(
   parameter int W = 13
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   input  wire logic         clr,
   input  wire logic         inc,
   output logic [W-1:0]      count_reg
);
   // clear wins over a tick in the same cycle; saturates rather than wraps
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         count_reg <= '0;
      else if (ce && clr)
         count_reg <= '0;
      else if (ce && inc && (count_reg != '1))
         count_reg <= count_reg + W'(1);
   end
endmodule : acpfc_tick_counter

// ===== src/acpfc_delay_rom.sv
// firing delay lookup table with registered read data
`timescale 1ns/10ps
module acpfc_delay_rom
   import acpfc_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       ce,
   input  wire logic [acpfc_pkg::IDX_W-1:0] addr,
   output logic [acpfc_pkg::CNT_W-1:0]     data_reg
);
   // out-of-range index reads the last entry, the shortest delay
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         data_reg <= DELAY_LUT[0];
      else if (ce)
         data_reg <= (addr < IDX_W'(LUT_N)) ? DELAY_LUT[addr] : DELAY_LUT[LUT_N-1];
   end

   // higher set-point index always means a shorter delay, hence more speed
   AST_LUT_MONO: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && addr != '0 && addr < IDX_W'(LUT_N)) |=> (data_reg < DELAY_LUT[$past(addr) - 1]))
      else $error("delay table not decreasing with index");
endmodule : acpfc_delay_rom

// ===== test/acpfc_line_model.sv
// partner model: mains zero-crossing comparator and potentiometer converter
`timescale 1ns/10ps
module acpfc_line_model
   import acpfc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  run,
   input  wire logic [15:0]           half_cyc,
   input  wire logic [9:0]            code_in,
   input  wire logic                  adc_start_out,
   output logic                       mains_sense_in,
   output acpfc_pkg::acpfc_adc_t      setpoint_adc_in
);
   logic [15:0] half_cnt_reg;
   logic [3:0]  conv_cnt_reg;
   logic        busy_reg;
   logic        slow_reg;

   // ----------------------------------------------------------------------
   // mains comparator
   // ----------------------------------------------------------------------
   // one level change per half period; holds its level while stopped
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         half_cnt_reg   <= 16'h0000;
         mains_sense_in <= #1 1'b0;
      end
      else if (!run)
         half_cnt_reg <= 16'h0000;
      else if (half_cnt_reg == half_cyc - 16'h0001)
      begin
         half_cnt_reg   <= 16'h0000;
         mains_sense_in <= #1 ~mains_sense_in;
      end
      else
         half_cnt_reg <= half_cnt_reg + 16'h0001;
   end

   // ----------------------------------------------------------------------
   // potentiometer converter
   // ----------------------------------------------------------------------
   // latency alternates prompt and slow; idle code toggles every cycle so a
   // design that reads it without the strobe picks up garbage
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busy_reg        <= 1'b0;
         conv_cnt_reg    <= 4'h0;
         slow_reg        <= 1'b0;
         setpoint_adc_in <= #1 {1'b0, 10'h000};
      end
      else if (!busy_reg)
      begin
         setpoint_adc_in <= #1 {1'b0, ~setpoint_adc_in.code};
         if (adc_start_out)
         begin
            busy_reg     <= 1'b1;
            conv_cnt_reg <= slow_reg ? 4'h9 : 4'h1;
            slow_reg     <= ~slow_reg;
         end
      end
      else if (conv_cnt_reg == 4'h0)
      begin
         busy_reg        <= 1'b0;
         setpoint_adc_in <= #1 {1'b1, code_in};
      end
      else
         conv_cnt_reg <= conv_cnt_reg - 4'h1;
   end
endmodule : acpfc_line_model

// ===== test/acpfc_firing_ctrl_test.sv
// self-checking testbench of the ac phase firing controller
`timescale 1ns/10ps
module acpfc_firing_ctrl_test;
   import acpfc_pkg::*;
   logic                  clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic                  clk_en = 1'b1;
   logic                  run = 1'b0;
   logic [15:0]           half_cyc = 16'h1680;
   logic [9:0]            code_in = 10'h208;
   logic                  mains_sense_in;
   acpfc_adc_t            setpoint_adc_in;
   logic                  triac_gate_out;
   logic                  adc_start_out;
   acpfc_stat_t           status_out;
   int err_count = 0, check_count = 0;
   int cyc = 0, xings = 0, fires = 0, xc_time = 0, rise_time = 0;
   int delay = 0, width = 0, bad_gate = 0;
   logic mains_q = 1'b0, gate_q = 1'b0;

   // one tick per clock keeps every half period at a few thousand cycles
   acpfc_firing_ctrl #(.TICK_DIV(1)) i_acpfc_firing_ctrl (.clk(clk), .rst_b(rst_b),
      .clk_en(clk_en), .mains_sense_in(mains_sense_in), .setpoint_adc_in(setpoint_adc_in),
      .triac_gate_out(triac_gate_out), .adc_start_out(adc_start_out), .status_out(status_out));
   acpfc_line_model i_acpfc_line_model (.clk(clk), .rst_b(rst_b), .run(run),
      .half_cyc(half_cyc), .code_in(code_in), .adc_start_out(adc_start_out),
      .mains_sense_in(mains_sense_in), .setpoint_adc_in(setpoint_adc_in));

   always #5 clk = ~clk;

   // ----------------------------------------------------------------------
   // monitor: crossings, gate edges, delay and width in cycles
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      cyc++;
      if (mains_sense_in !== mains_q)
      begin
         xings++;
         xc_time = cyc;
      end
      if (triac_gate_out === 1'b1 && gate_q !== 1'b1)
      begin
         fires++;
         rise_time = cyc;
         delay = cyc - xc_time;
      end
      if (triac_gate_out === 1'b0 && gate_q === 1'b1)
         width = cyc - rise_time;
      if (triac_gate_out !== 1'b0 && status_out.freq_ok !== 1'b1)
         bad_gate++;
      mains_q = mains_sense_in;
      gate_q = triac_gate_out;
   end

   // ----------------------------------------------------------------------
   // common tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         err_count++;
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic step;
      @(posedge clk);
      #1;
   endtask : step

   // bounded wait for the next gate rise
   task automatic wait_fire(input int lim);
      int n0;
      n0 = fires;
      for (int i = 0; i < lim && fires == n0; i++)
         step();
   endtask : wait_fire

   task automatic wait_xing(input int lim);
      int n0;
      n0 = xings;
      for (int i = 0; i < lim && xings == n0; i++)
         step();
   endtask : wait_xing

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   // reset with mains stopped, then configure edge before the first request
   task automatic t_reset(input logic [15:0] half);
      run = 1'b0;
      half_cyc = half;
      rst_b = 1'b0;
      repeat (5) step();
      check({triac_gate_out, adc_start_out, status_out}, 32'h0);
      rst_b = 1'b1;
      step();
      check(adc_start_out, 32'h0);
      step();
      check(adc_start_out, 32'h1);
      xings = 0;
      fires = 0;
      bad_gate = 0;
   endtask : t_reset

   // classification needs one starting crossing plus five equal results
   task automatic t_detect(input logic [15:0] half, input logic [2:0] exp);
      t_reset(half);
      run = 1'b1;
      for (int i = 0; i < 8 * half && status_out.freq_ok !== 1'b1; i++)
         step();
      check(status_out, exp);
      check(xings, 32'h6);
      check(bad_gate, 32'h0);
   endtask : t_detect

   // standstill at the lowest setting first, since the half period after
   // acceptance is never armed anyway; then the delay follows the table
   task automatic t_fire60;
      int d10, x10, f0;
      code_in = 10'h00A;
      wait_xing(6000);
      f0 = fires;
      code_in = 10'h208;
      wait_xing(6000);
      check(fires, f0);
      wait_fire(6000);
      d10 = delay;
      x10 = xings - fires;
      check(d10 >= DELAY_LUT[10] + 1 && d10 <= DELAY_LUT[10] + 5, 32'h1);
      for (int i = 0; i < 200 && triac_gate_out === 1'b1; i++)
         step();
      // the monitor sees the falling edge one clock later
      step();
      check(width >= GATE_TK - 1 && width <= GATE_TK + 2, 32'h1);
      code_in = 10'h3E8;
      wait_fire(6000);
      check(delay >= DELAY_LUT[19] + 1 && delay <= DELAY_LUT[19] + 5, 32'h1);
      check(delay < d10, 32'h1);
      check(xings - fires, x10);
      check(bad_gate, 32'h0);
   endtask : t_fire60

   // no mains at all: lock out, and later short pulses must not recover it
   task automatic t_halt;
      t_reset(16'h03E8);
      for (int i = 0; i < 8100 && status_out.halted !== 1'b1; i++)
         step();
      check(status_out, 32'h4);
      run = 1'b1;
      repeat (2500) step();
      check(status_out, 32'h4);
      check(fires, 32'h0);
   endtask : t_halt

   // ----------------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------------
   initial
   begin
      t_detect(16'h1680, 3'h2);
      t_fire60();
      t_halt();
      t_detect(16'h1B00, 3'h3);
      close_out();
   end

   // the sequence needs about 104k cycles; cut a hang well beyond that
   initial
   begin
      repeat (130000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule : acpfc_firing_ctrl_test
